//--- logic/dpbr_pkg.sv
// Shared constants, field layouts and types of the dual-port block memory
package dpbr_pkg;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int         DATA_W        = 32;
  localparam int         PAR_W         = 4;
  localparam int         ADDR_W        = 14;
  localparam int         WORD_AW       = 9;
  localparam int         WORDS         = 512;
  localparam int         BYTE_W        = 8;
  localparam int         STRB_W        = 4;
  // Width codes: 0..5 give 1, 2, 4, 9, 18, 36 bits
  localparam logic [2:0] WCODE_MAX     = 3'h5;
  localparam logic [2:0] WCODE_PAR_MIN = 3'h3;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int          AXI_AW       = 12;
  localparam logic [11:0] OFF_CFG_A    = 12'h000;
  localparam logic [11:0] OFF_CFG_B    = 12'h004;
  localparam logic [11:0] OFF_DOUT_A   = 12'h008;
  localparam logic [11:0] OFF_DOUT_B   = 12'h00c;
  localparam logic [11:0] OFF_PAR      = 12'h010;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       read_first;
    logic       falling;
    logic [2:0] wcode;
  } dpbr_cfg_s;

  localparam dpbr_cfg_s CFG_RST = '{read_first: 1'b0, falling: 1'b0, wcode: 3'h5};

  typedef struct packed {
    logic                select;
    logic                write_strobe;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   write_word_in;
    logic [PAR_W-1:0]    parity_in;
  } dpbr_pins_s;

  typedef struct packed {
    logic [WORD_AW-1:0]  word;
    logic [4:0]          off;
    logic [DATA_W-1:0]   dmask;
    logic [WORD_AW-1:0]  pword;
    logic [1:0]          poff;
    logic [PAR_W-1:0]    pmask;
  } dpbr_lane_s;

  // ---------------------------------------------------------------
  // Address to storage lane decode for a port's width
  // ---------------------------------------------------------------
  function automatic dpbr_lane_s dpbr_lane(input dpbr_cfg_s cfg, input logic [ADDR_W-1:0] addr);
    logic [2:0]        lg;
    logic [ADDR_W-1:0] am;
    logic [ADDR_W-1:0] pos;
    logic [10:0]       ppos;
    logic [5:0]        dw;
    logic [2:0]        pw;
    lg   = (cfg.wcode > WCODE_MAX) ? WCODE_MAX : cfg.wcode;
    am   = addr & (14'h3fff >> lg);
    pos  = am << lg;
    dw   = 6'h01 << lg;
    pw   = (lg >= WCODE_PAR_MIN) ? (3'h1 << (lg - WCODE_PAR_MIN)) : 3'h0;
    ppos = (lg >= WCODE_PAR_MIN) ? 11'(am << (lg - WCODE_PAR_MIN)) : 11'h000;
    dpbr_lane.word  = pos[13:5];
    dpbr_lane.off   = pos[4:0];
    dpbr_lane.dmask = ~(32'hffffffff << dw);
    dpbr_lane.pword = ppos[10:2];
    dpbr_lane.poff  = ppos[1:0];
    dpbr_lane.pmask = ~(4'hf << pw);
  endfunction : dpbr_lane

endpackage : dpbr_pkg

//--- logic/dpbr_port_sync.sv
// Samples one user port's clock and pins into aclk and flags its active edge
`timescale 1ns/1ps
module dpbr_port_sync (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // User port pins
  input  wire logic                 port_clk,
  input  wire dpbr_pkg::dpbr_pins_s pins_in,
  // Edge choice
  input  wire logic                 falling,
  // Sampled port
  output logic                      edge_seen,
  output dpbr_pkg::dpbr_pins_s      pins_out
);

  logic                 clk_s1_r;
  logic                 clk_s2_r;
  logic                 clk_s3_r;
  dpbr_pkg::dpbr_pins_s pins_s1_r;
  dpbr_pkg::dpbr_pins_s pins_s2_r;

  // ---------------------------------------------------------------
  // Three-stage sampling of clock, two-stage sampling of pins
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
    end else begin
      clk_s1_r <= port_clk;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_s1_r <= '0;
      pins_s2_r <= '0;
    end else begin
      pins_s1_r <= pins_in;
      pins_s2_r <= pins_s1_r;
    end
  end

  assign pins_out  = pins_s2_r;
  // (RULE6) chosen edge polarity
  assign edge_seen = falling ? (!clk_s2_r && clk_s3_r) : (clk_s2_r && !clk_s3_r);

endmodule : dpbr_port_sync

//--- logic/dpbr_top.sv
// Dual-port block memory with sampled user ports and AXI4-Lite configuration
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// (RULE1) Two ports with their own pins and clocks work independently of each other.
// (RULE2) Ports can be 1x16384, 2x8192 or 4x4096 without parity bits.
// (RULE3) Ports can be 9x2048, 18x1024 or 36x512, one parity bit per data byte.
// (RULE4) An enabled edge with write strobe low loads the addressed word into the output.
// (RULE5) An enabled edge with write strobe high stores the input word at the address.
// (RULE6) Each port's active clock edge is rising or falling by configuration.
// (RULE7) Every write also updates the port output, in a configured manner.
// (RULE8) Transparent mode places the written word on the output.
// (RULE9) Read-before-write mode places the cell's prior content on the output.
// (RULE10) With the port not selected, neither memory nor output changes.
module dpbr_top (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write channels
  input  wire logic [dpbr_pkg::AXI_AW-1:0]   awaddr,
  input  wire logic [2:0]                    awprot,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [dpbr_pkg::DATA_W-1:0]   wdata,
  input  wire logic [dpbr_pkg::STRB_W-1:0]   wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  // AXI4-Lite read channels
  input  wire logic [dpbr_pkg::AXI_AW-1:0]   araddr,
  input  wire logic [2:0]                    arprot,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [dpbr_pkg::DATA_W-1:0]        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // Port A
  input  wire logic                          port_a_clk,
  input  wire dpbr_pkg::dpbr_pins_s          port_a_in,
  output logic [dpbr_pkg::DATA_W-1:0]        port_a_read_word,
  output logic [dpbr_pkg::PAR_W-1:0]         port_a_parity_out,
  // Port B
  input  wire logic                          port_b_clk,
  input  wire dpbr_pkg::dpbr_pins_s          port_b_in,
  output logic [dpbr_pkg::DATA_W-1:0]        port_b_read_word,
  output logic [dpbr_pkg::PAR_W-1:0]         port_b_parity_out
);

  dpbr_pkg::dpbr_cfg_s          cfg_a_r;
  dpbr_pkg::dpbr_cfg_s          cfg_b_r;
  logic                         edge_a;
  logic                         edge_b;
  dpbr_pkg::dpbr_pins_s         pa;
  dpbr_pkg::dpbr_pins_s         pb;
  dpbr_pkg::dpbr_lane_s         la;
  dpbr_pkg::dpbr_lane_s         lb;
  logic [dpbr_pkg::DATA_W-1:0]  mem_d [dpbr_pkg::WORDS];
  logic [dpbr_pkg::PAR_W-1:0]   mem_p [dpbr_pkg::WORDS];
  logic [dpbr_pkg::DATA_W-1:0]  old_da, old_db, wa_bits, wb_bits, da_new, db_new;
  logic [dpbr_pkg::PAR_W-1:0]   old_pa, old_pb, pa_new, pb_new;
  logic                         en_a, en_b, we_a, we_b;
  logic [dpbr_pkg::DATA_W-1:0]  dout_a_r, dout_b_r;
  logic [dpbr_pkg::PAR_W-1:0]   par_a_r, par_b_r;
  logic                         aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [dpbr_pkg::AXI_AW-1:0]  awaddr_r;
  logic [dpbr_pkg::DATA_W-1:0]  wdata_r, rdata_r;
  logic [dpbr_pkg::STRB_W-1:0]  wstrb_r;
  logic [1:0]                   bresp_r, rresp_r;
  logic                         wr_go;
  logic [dpbr_pkg::WORD_AW-1:0] a_word;
  logic [4:0]                   a_off;
  logic [dpbr_pkg::DATA_W-1:0]  a_dmask;
  logic [dpbr_pkg::PAR_W-1:0]   a_pmask;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] mask,
                                             input logic [4:0] off, input logic [31:0] val);
    lane_merge = (old & ~(mask << off)) | ((val & mask) << off);
  endfunction : lane_merge

  function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] val,
                                               input logic [3:0] strb);
    strobe_merge = old;
    for (int i = 0; i < dpbr_pkg::STRB_W; i++) begin
      if (strb[i]) begin
        strobe_merge[i*dpbr_pkg::BYTE_W +: dpbr_pkg::BYTE_W] =
          val[i*dpbr_pkg::BYTE_W +: dpbr_pkg::BYTE_W];
      end
    end
  endfunction : strobe_merge

  function automatic logic [11:0] word_of(input logic [11:0] addr);
    word_of = {addr[11:2], 2'h0};
  endfunction : word_of

  // ---------------------------------------------------------------
  // Port sampling
  // ---------------------------------------------------------------
  // (RULE1) separate sampling per port
  dpbr_port_sync u_sync_a (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .port_clk  (port_a_clk),
    .pins_in   (port_a_in),
    .falling   (cfg_a_r.falling),
    .edge_seen (edge_a),
    .pins_out  (pa)
  );

  dpbr_port_sync u_sync_b (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .port_clk  (port_b_clk),
    .pins_in   (port_b_in),
    .falling   (cfg_b_r.falling),
    .edge_seen (edge_b),
    .pins_out  (pb)
  );

  // ---------------------------------------------------------------
  // Lane decode and read of old content
  // ---------------------------------------------------------------
  // (RULE2) width sets data lane
  assign la      = dpbr_pkg::dpbr_lane(cfg_a_r, pa.addr);
  assign lb      = dpbr_pkg::dpbr_lane(cfg_b_r, pb.addr);
  assign old_da  = (mem_d[la.word] >> la.off) & la.dmask;
  assign old_db  = (mem_d[lb.word] >> lb.off) & lb.dmask;
  // (RULE3) parity lane per byte
  assign old_pa  = (mem_p[la.pword] >> la.poff) & la.pmask;
  assign old_pb  = (mem_p[lb.pword] >> lb.poff) & lb.pmask;
  assign wa_bits = pa.write_word_in & la.dmask;
  assign wb_bits = pb.write_word_in & lb.dmask;
  // (RULE10) select gates every action
  assign en_a    = edge_a && pa.select;
  assign en_b    = edge_b && pb.select;
  assign we_a    = en_a && pa.write_strobe;
  assign we_b    = en_b && pb.write_strobe;

  // ---------------------------------------------------------------
  // Memory array
  // ---------------------------------------------------------------
  // Port B merges on top of port A's result so narrow lanes of one word both land
  assign da_new = lane_merge(mem_d[la.word], la.dmask, la.off, pa.write_word_in);
  assign db_new = lane_merge((we_a && la.word == lb.word) ? da_new : mem_d[lb.word],
                             lb.dmask, lb.off, pb.write_word_in);
  assign pa_new = 4'(lane_merge(32'(mem_p[la.pword]), 32'(la.pmask), 5'(la.poff),
                                32'(pa.parity_in)));
  assign pb_new = 4'(lane_merge(32'((we_a && la.pword == lb.pword) ? pa_new : mem_p[lb.pword]),
                                32'(lb.pmask), 5'(lb.poff), 32'(pb.parity_in)));

  // (RULE5) store on enabled write edge
  always_ff @(posedge aclk) begin
    if (we_a) begin
      mem_d[la.word]  <= da_new;
      mem_p[la.pword] <= pa_new;
    end
    if (we_b) begin
      mem_d[lb.word]  <= db_new;
      mem_p[lb.pword] <= pb_new;
    end
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  // (RULE7) write also updates output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout_a_r <= '0;
      par_a_r  <= '0;
    end else if (en_a) begin
      // (RULE8) transparent write
      if (pa.write_strobe && !cfg_a_r.read_first) begin
        dout_a_r <= wa_bits;
        par_a_r  <= pa.parity_in & la.pmask;
      // (RULE4) read or read-before-write
      end else begin
        dout_a_r <= old_da;
        par_a_r  <= old_pa;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout_b_r <= '0;
      par_b_r  <= '0;
    end else if (en_b) begin
      // (RULE8) transparent write
      if (pb.write_strobe && !cfg_b_r.read_first) begin
        dout_b_r <= wb_bits;
        par_b_r  <= pb.parity_in & lb.pmask;
      // (RULE9) prior content out
      end else begin
        dout_b_r <= old_db;
        par_b_r  <= old_pb;
      end
    end
  end

  assign port_a_read_word  = dout_a_r;
  assign port_a_parity_out = par_a_r;
  assign port_b_read_word  = dout_b_r;
  assign port_b_parity_out = par_b_r;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  assign awready = !aw_hold_r && !bvalid_r;
  assign wready  = !w_hold_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign wr_go   = aw_hold_r && w_hold_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end else if (wr_go) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= dpbr_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      unique case (word_of(awaddr_r))
        dpbr_pkg::OFF_CFG_A, dpbr_pkg::OFF_CFG_B, dpbr_pkg::OFF_DOUT_A,
        dpbr_pkg::OFF_DOUT_B, dpbr_pkg::OFF_PAR: bresp_r <= dpbr_pkg::RESP_OKAY;
        default: bresp_r <= dpbr_pkg::RESP_SLVERR;
      endcase
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // (RULE6) edge and write mode per port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_a_r <= dpbr_pkg::CFG_RST;
      cfg_b_r <= dpbr_pkg::CFG_RST;
    end else if (wr_go) begin
      if (word_of(awaddr_r) == dpbr_pkg::OFF_CFG_A) begin
        cfg_a_r <= 5'(strobe_merge(32'(cfg_a_r), wdata_r, wstrb_r));
      end
      if (word_of(awaddr_r) == dpbr_pkg::OFF_CFG_B) begin
        cfg_b_r <= 5'(strobe_merge(32'(cfg_b_r), wdata_r, wstrb_r));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= dpbr_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= dpbr_pkg::RESP_OKAY;
      unique case (word_of(araddr))
        dpbr_pkg::OFF_CFG_A:  rdata_r <= 32'(cfg_a_r);
        dpbr_pkg::OFF_CFG_B:  rdata_r <= 32'(cfg_b_r);
        dpbr_pkg::OFF_DOUT_A: rdata_r <= dout_a_r;
        dpbr_pkg::OFF_DOUT_B: rdata_r <= dout_b_r;
        dpbr_pkg::OFF_PAR:    rdata_r <= 32'({par_b_r, par_a_r});
        default: begin
          rdata_r <= '0;
          rresp_r <= dpbr_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  assign a_word  = la.word;
  assign a_off   = la.off;
  assign a_dmask = la.dmask;
  assign a_pmask = la.pmask;

  a_port_b_read: assert property ( // RULE1
    @(posedge aclk) disable iff (!aresetn)
    en_b && !pb.write_strobe |=> dout_b_r == $past(old_db))
    else $error("port B read did not load stored word");
  a_narrow_data_mask: assert property ( // RULE2
    @(posedge aclk) disable iff (!aresetn)
    en_a |=> (dout_a_r & ~$past(a_dmask)) == '0)
    else $error("port A output has bits beyond its width");
  a_parity_lane_mask: assert property ( // RULE3
    @(posedge aclk) disable iff (!aresetn)
    en_a |=> (par_a_r & ~$past(a_pmask)) == '0)
    else $error("port A parity has bits beyond its width");
  a_read_loads_out: assert property ( // RULE4
    @(posedge aclk) disable iff (!aresetn)
    en_a && !pa.write_strobe |=> dout_a_r == $past(old_da))
    else $error("port A read did not load stored word");
  a_write_stores_cell: assert property ( // RULE5
    @(posedge aclk) disable iff (!aresetn)
    we_a && !(we_b && lb.word == la.word)
    |=> ((mem_d[$past(a_word)] >> $past(a_off)) & $past(a_dmask)) == $past(wa_bits))
    else $error("port A write not found in memory");
  a_edge_gates_out: assert property ( // RULE6
    @(posedge aclk) disable iff (!aresetn)
    !edge_a ##1 !edge_a |-> $stable(dout_a_r))
    else $error("port A output moved without an active edge");
  a_write_updates_out: assert property ( // RULE7
    @(posedge aclk) disable iff (!aresetn)
    we_b |=> dout_b_r == ($past(cfg_b_r.read_first) ? $past(old_db) : $past(wb_bits)))
    else $error("port B write did not update output");
  a_transparent_write: assert property ( // RULE8
    @(posedge aclk) disable iff (!aresetn)
    we_a && !cfg_a_r.read_first |=> dout_a_r == $past(wa_bits))
    else $error("transparent write output wrong");
  a_read_before_write: assert property ( // RULE9
    @(posedge aclk) disable iff (!aresetn)
    we_a && cfg_a_r.read_first |=> dout_a_r == $past(old_da))
    else $error("read-before-write output wrong");
  a_disabled_port_idle: assert property ( // RULE10
    @(posedge aclk) disable iff (!aresetn)
    edge_a && !pa.select |=> $stable(dout_a_r) && $stable(par_a_r))
    else $error("unselected port A changed output");

endmodule : dpbr_top

//--- verif/dpbr_user_port.sv
// Behavioural fabric user logic that drives one memory port
`timescale 1ns/1ps
module dpbr_user_port (
  // Clock
  input  wire logic            aclk,
  // Port pins
  output logic                 port_clk,
  output dpbr_pkg::dpbr_pins_s pins,
  // Output word seen from the port
  input  wire logic [31:0]     read_word
);
  initial begin
    port_clk = 1'b0;
    pins     = '0;
  end

  // ---------------------------------------------------------------
  // One port clock period around an access
  // ---------------------------------------------------------------
  task automatic cycle(input logic s, input logic w, input logic [13:0] a,
                       input logic [31:0] d, input logic [3:0] pd, output logic [31:0] mid);
    @(posedge aclk);
    pins <= '{select: s, write_strobe: w, addr: s ? a : ~a,
              write_word_in: s ? d : ~d, parity_in: s ? pd : ~pd};
    repeat (3) @(posedge aclk);
    port_clk <= 1'b1;
    repeat (3) @(posedge aclk);
    // Word just before the falling edge tells which edge acted
    @(negedge aclk);
    mid = read_word;
    @(posedge aclk);
    port_clk <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : cycle
endmodule : dpbr_user_port

//--- verif/tb.sv
// Testbench for the dual-port block memory against a behavioural store model
`timescale 1ns/1ps
module tb;
  // ---------------------------------------------------------------
  // Signals and model state
  // ---------------------------------------------------------------
  logic                 aclk = 1'b0;
  logic                 aresetn = 1'b0;
  logic [11:0]          awaddr = '0, araddr = '0;
  logic [31:0]          wdata = '0;
  logic                 awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic                 rready = 1'b0;
  logic                 awready, wready, bvalid, arready, rvalid, clk_a, clk_b;
  logic [1:0]           bresp, rresp;
  logic [31:0]          rdata, rw_a, rw_b;
  logic [3:0]           par_a, par_b;
  dpbr_pkg::dpbr_pins_s pin_a, pin_b;
  logic [18431:0]       mem_m;
  logic [31:0]          exp_w [2] = '{32'h0, 32'h0};
  logic [3:0]           exp_p [2] = '{4'h0, 4'h0};
  logic [4:0]           cfg_m [2] = '{5'h05, 5'h05};
  int                   fail_count = 0, compares = 0, cyc = 0;

  always #12.5 aclk = ~aclk;

  dpbr_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .port_a_clk(clk_a), .port_a_in(pin_a),
    .port_a_read_word(rw_a), .port_a_parity_out(par_a), .port_b_clk(clk_b),
    .port_b_in(pin_b), .port_b_read_word(rw_b), .port_b_parity_out(par_b));
  dpbr_user_port ua (.aclk(aclk), .port_clk(clk_a), .pins(pin_a), .read_word(rw_a));
  dpbr_user_port ub (.aclk(aclk), .port_clk(clk_b), .pins(pin_b), .read_word(rw_b));

  // ---------------------------------------------------------------
  // Checking, bus and model tasks
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tk;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tk = bvalid;
      r  = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tk) bready <= 1'b0;
    end while (!tk);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tk;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tk = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tk) rready <= 1'b0;
    end while (!tk);
  endtask : axi_rd

  task automatic set_cfg(input int p, input logic [4:0] v);
    logic [1:0]  r;
    logic [31:0] d;
    axi_wr(p ? dpbr_pkg::OFF_CFG_B : dpbr_pkg::OFF_CFG_A, {27'h0, v}, r);
    check("cfg_bresp", {30'h0, r}, {30'h0, dpbr_pkg::RESP_OKAY});
    cfg_m[p] = v;
    axi_rd(p ? dpbr_pkg::OFF_CFG_B : dpbr_pkg::OFF_CFG_A, d, r);
    check("cfg_rresp", {30'h0, r}, {30'h0, dpbr_pkg::RESP_OKAY});
    check("cfg", d, {27'h0, v});
  endtask : set_cfg

  task automatic m_acc(input int p, input logic s, input logic w, input logic [13:0] a,
                       input logic [31:0] d, input logic [3:0] pd);
    int c, am, pw;
    c  = (cfg_m[p][2:0] > 5) ? 5 : int'(cfg_m[p][2:0]);
    am = int'(a) & (16383 >> c);
    pw = (c >= 3) ? (1 << (c - 3)) : 0;
    if (!s) return;
    exp_w[p] = '0;
    exp_p[p] = '0;
    for (int i = 0; i < (1 << c); i++) begin
      exp_w[p][i] = (w && !cfg_m[p][4]) ? d[i] : mem_m[(am << c) + i];
      if (w) mem_m[(am << c) + i] = d[i];
    end
    for (int i = 0; i < pw; i++) begin
      exp_p[p][i] = (w && !cfg_m[p][4]) ? pd[i] : mem_m[16384 + am * pw + i];
      if (w) mem_m[16384 + am * pw + i] = pd[i];
    end
  endtask : m_acc

  task automatic port_op(input int p, input logic s, input logic w, input logic [13:0] a,
                         input logic [31:0] d, input logic [3:0] pd);
    logic [31:0] mid, old;
    old = exp_w[p];
    if (p == 0) ua.cycle(s, w, a, d, pd, mid);
    else ub.cycle(s, w, a, d, pd, mid);
    m_acc(p, s, w, a, d, pd);
    check("read_word", p ? rw_b : rw_a, exp_w[p]);
    check("parity", {28'h0, p ? par_b : par_a}, {28'h0, exp_p[p]});
    check("mid_word", mid, cfg_m[p][3] ? old : exp_w[p]);
  endtask : port_op

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [13:0] a;
    int          lb;
    void'($urandom(12));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axi_rd(dpbr_pkg::OFF_CFG_B, d, r);
    check("cfg_reset", d, 32'h05);
    axi_rd(12'h020, d, r);
    check("rd_unmapped", {30'h0, r}, {30'h0, dpbr_pkg::RESP_SLVERR});
    axi_wr(12'h024, $urandom, r);
    check("wr_unmapped", {30'h0, r}, {30'h0, dpbr_pkg::RESP_SLVERR});
    axi_wr(dpbr_pkg::OFF_DOUT_A, $urandom, r);
    check("wr_readonly", {30'h0, r}, {30'h0, dpbr_pkg::RESP_OKAY});
    // Both ports fill the whole store at once
    for (int i = 0; i < 512; i += 2) begin
      fork
        port_op(0, 1'b1, 1'b1, 14'(i), $urandom, 4'($urandom));
        port_op(1, 1'b1, 1'b1, 14'(i + 1), $urandom, 4'($urandom));
      join
    end
    // Every width code on A, edge and write mode cycling through all four pairs, mixed widths on B
    for (int c = 0; c < 8; c++) begin
      lb = (c < 6) ? 5 - c : c;
      set_cfg(0, {c[1:0], c[2:0]});
      set_cfg(1, {~c[1:0], lb[2:0]});
      lb = (lb > 5) ? 5 : lb;
      a  = 14'($urandom);
      port_op(0, 1'b1, 1'b1, a, $urandom, 4'($urandom));
      port_op(0, 1'b1, 1'b1, a, $urandom, 4'($urandom));
      port_op(0, 1'b0, 1'b1, a, $urandom, 4'($urandom));
      port_op(0, 1'b1, 1'b0, a, '0, '0);
      port_op(1, 1'b1, 1'b0, 14'(((int'(a) & (16383 >> (c > 5 ? 5 : c)))
              << (c > 5 ? 5 : c)) >> lb), '0, '0);
    end
    axi_rd(dpbr_pkg::OFF_DOUT_A, d, r);
    check("dout_a", d, exp_w[0]);
    axi_rd(dpbr_pkg::OFF_DOUT_B, d, r);
    check("dout_b", d, exp_w[1]);
    axi_rd(dpbr_pkg::OFF_PAR, d, r);
    check("par_regs", d, {24'h0, exp_p[1], exp_p[0]});
    print_verdict();
  end
endmodule : tb
